/* File: hw/scd_bus_direction.sv */
// Data bus direction for each cycle kind and bus ownership
module scd_bus_direction (
  input  wire logic              clk,
  input  wire logic              rstn,
  scd_cfg_if.dst                 cfg,
  input  wire scd_pkg::scd_cycle_t cycle,
  input  wire logic              busMaster,
  input  wire logic              daisyIn,
  output logic                   dataOe,
  output logic                   dataIn
);
  function automatic scd_pkg::scd_dir_t dirOf(input scd_pkg::scd_cycle_t c,
                                              input logic m, input logic e, input logic d);
    scd_pkg::scd_dir_t r;
    r = scd_pkg::SCD_DIR_Z;
    unique case (c)
      scd_pkg::SCD_CYC_IO_WR_ON:  r = m ? scd_pkg::SCD_DIR_OUT : scd_pkg::SCD_DIR_Z;
      scd_pkg::SCD_CYC_IO_RD_ON:  r = (!m || e) ? scd_pkg::SCD_DIR_OUT
                                                : scd_pkg::SCD_DIR_Z;
      scd_pkg::SCD_CYC_IO_WR_OFF: r = m ? scd_pkg::SCD_DIR_OUT : scd_pkg::SCD_DIR_Z;
      scd_pkg::SCD_CYC_IO_RD_OFF: r = m ? scd_pkg::SCD_DIR_IN : scd_pkg::SCD_DIR_Z;
      scd_pkg::SCD_CYC_MEM_WR:    r = m ? scd_pkg::SCD_DIR_OUT : scd_pkg::SCD_DIR_Z;
      scd_pkg::SCD_CYC_MEM_RD:    r = scd_pkg::SCD_DIR_IN;
      scd_pkg::SCD_CYC_INTACK:
        if (!d) r = scd_pkg::SCD_DIR_IN;
        else    r = (!m || e) ? scd_pkg::SCD_DIR_OUT : scd_pkg::SCD_DIR_Z;
      default:                    r = scd_pkg::SCD_DIR_Z;
    endcase
    return r;
  endfunction

  wire scd_pkg::scd_dir_t dir = dirOf(cycle, busMaster, cfg.exportDir, daisyIn);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dataOe <= 1'b0;
      dataIn <= 1'b0;
    end else begin
      dataOe <= dir == scd_pkg::SCD_DIR_OUT;
      dataIn <= dir == scd_pkg::SCD_DIR_IN;
    end
  end
endmodule

/* File: hw/scd_cfg_if.sv */
// Configuration fields passed from the register file to the decoders
interface scd_cfg_if;
  logic       exportDir;
  logic       romDisable;
  logic [1:0] pinSel;
  logic       daisyOrder;
  logic [7:0] ramUpper;
  logic [7:0] ramLower;
  logic [7:0] romUpper;
  modport src (output exportDir, output romDisable, output pinSel, output daisyOrder,
               output ramUpper, output ramLower, output romUpper);
  modport dst (input exportDir, input romDisable, input pinSel, input daisyOrder,
               input ramUpper, input ramLower, input romUpper);
endinterface

/* File: hw/scd_chip_select.sv */
// Memory chip-select decoder against the three boundary registers
module scd_chip_select (
  input  wire logic       clk,
  input  wire logic       rstn,
  scd_cfg_if.dst          cfg,
  input  wire logic       memCycle,
  input  wire logic [7:0] addrHigh,
  output logic            romSelectN,
  output logic            ramSelectN
);
  wire logic inRom  = addrHigh <= cfg.romUpper;
  wire logic inRam  = (addrHigh <= cfg.ramUpper) && (addrHigh >= cfg.ramLower);
  wire logic romHit = memCycle && inRom && !cfg.romDisable;
  wire logic ramHit = memCycle && inRam && !romHit;

  // Registered so the selects are glitch free toward external memory
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      romSelectN <= 1'b1;
      ramSelectN <= 1'b1;
    end else begin
      romSelectN <= !romHit;
      ramSelectN <= !ramHit;
    end
  end
endmodule

/* File: hw/scd_pkg.sv */
// Constants and types shared by the configuration and chip-select decoder
// Contract
// - Export bit set reverses data bus in selected internal cycles to show them outside.
// - Master reading on-chip I/O: float when export zero, drive when export one.
// - Master: drive on writes, receive on off-chip/memory reads, float refresh and idle.
// - Master intack: receive when daisy input low; on-chip: float or drive by export.
// - Not master: drive only for on-chip reads and on-chip intack, receive on memory reads and off-chip intack; otherwise float, export ignored.
// - Not master intack: drive for on-chip source, receive for off-chip source.
// - ROM disable one keeps ROM select inactive; zero lets ROM range assert it.
// - Two pin-select bits route the three triple-multiplexed pins per code.
// - Channel-select zero: both serial channels and parallel port on, host port off.
// - Channel-select one: channel B outputs off, parallel port off, host port on.
// - Daisy bit zero ranks serial controller first; one ranks emulation port first.
// - Serial and emulation interrupts share the interrupt zero request line.
// - RAM select asserts for memory address 19..12 within lower and upper bounds.
// - ROM select asserts for memory address 19..12 at or below ROM boundary.
// - On overlap only ROM select asserts; RAM select stays inactive.
// - Decoder uses CPU address bit 18 taken before timer output multiplexing.
// - All three boundary registers reset to all ones.
// - ROM disable forces ROM select inactive so RAM may overlay ROM.
package scd_pkg;
  localparam logic [7:0] SCD_ADDR_RAM_UB  = 8'he6;
  localparam logic [7:0] SCD_ADDR_RAM_LB  = 8'he7;
  localparam logic [7:0] SCD_ADDR_ROM_UB  = 8'he8;
  localparam logic [7:0] SCD_ADDR_SYSCFG  = 8'hef;
  localparam logic [7:0] SCD_BOUND_RESET  = 8'hff;
  localparam logic [7:0] SCD_SYSCFG_RESET = 8'h00;
  localparam int SCD_BIT_EXPORT   = 4;
  localparam int SCD_BIT_ROM_DIS  = 3;
  localparam int SCD_BIT_PINSEL_H = 2;
  localparam int SCD_BIT_PINSEL_L = 1;
  localparam int SCD_BIT_CHANSEL  = 1;
  localparam int SCD_BIT_DAISY    = 0;

  // Bus cycle kinds seen by the direction logic
  typedef enum logic [3:0] {
    SCD_CYC_IDLE,
    SCD_CYC_IO_WR_ON,
    SCD_CYC_IO_RD_ON,
    SCD_CYC_IO_WR_OFF,
    SCD_CYC_IO_RD_OFF,
    SCD_CYC_MEM_WR,
    SCD_CYC_MEM_RD,
    SCD_CYC_REFRESH,
    SCD_CYC_INTACK
  } scd_cycle_t;

  typedef enum logic [1:0] {
    SCD_DIR_Z,
    SCD_DIR_OUT,
    SCD_DIR_IN
  } scd_dir_t;

  typedef enum logic [1:0] {
    SCD_PINS_SERIAL,
    SCD_PINS_CHAN_B,
    SCD_PINS_HOST
  } scd_pins_t;
endpackage

/* File: hw/scd_top.sv */
// System configuration register, pin routing and chip-select decoding top
module scd_top (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic [7:0]          ioAddr,
  input  wire logic                ioWrite,
  input  wire logic                ioRead,
  input  wire logic [7:0]          ioWrData,
  output logic      [7:0]          ioRdData,
  output logic                     ioRdHit,
  input  wire scd_pkg::scd_cycle_t cycle,
  input  wire logic                busMaster,
  input  wire logic                daisyChainIn,
  input  wire logic [7:0]          memAddrHigh,
  output logic                     dataOe,
  output logic                     dataIn,
  output logic                     romSelectN,
  output logic                     ramSelectN,
  input  wire logic                dma1TransferEndN,
  input  wire logic                clockedSerialTransmit,
  input  wire logic                clockedSerialClock,
  input  wire logic                chanBRequestToSendN,
  input  wire logic                chanBReadyReqN,
  input  wire logic                chanBWaitReqN,
  input  wire logic                hostReceiveReadyN,
  input  wire logic                hostTransmitReadyN,
  input  wire logic                hostInterrupt,
  output logic      [2:0]          muxPinOut,
  output scd_pkg::scd_pins_t       muxPinMode,
  output logic                     chanBOutEnable,
  output logic                     parallelPortEnable,
  output logic                     hostPortEnable,
  input  wire logic                serialIrq,
  input  wire logic                hostPortIrq,
  output logic                     sharedIrqZeroN,
  output logic                     hostPortFirst
);
  logic [7:0] sysCfg_q;
  logic [7:0] ramUb_q;
  logic [7:0] ramLb_q;
  logic [7:0] romUb_q;

  scd_cfg_if cfg ();

  wire logic wrCfg = ioWrite && ioAddr == scd_pkg::SCD_ADDR_SYSCFG;
  wire logic wrRUb = ioWrite && ioAddr == scd_pkg::SCD_ADDR_RAM_UB;
  wire logic wrRLb = ioWrite && ioAddr == scd_pkg::SCD_ADDR_RAM_LB;
  wire logic wrRom = ioWrite && ioAddr == scd_pkg::SCD_ADDR_ROM_UB;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sysCfg_q <= scd_pkg::SCD_SYSCFG_RESET;
      ramUb_q  <= scd_pkg::SCD_BOUND_RESET;
      ramLb_q  <= scd_pkg::SCD_BOUND_RESET;
      romUb_q  <= scd_pkg::SCD_BOUND_RESET;
    end else begin
      if (wrCfg) sysCfg_q <= ioWrData;
      if (wrRUb) ramUb_q  <= ioWrData;
      if (wrRLb) ramLb_q  <= ioWrData;
      if (wrRom) romUb_q  <= ioWrData;
    end
  end

  wire logic hitAny = ioAddr == scd_pkg::SCD_ADDR_SYSCFG || ioAddr == scd_pkg::SCD_ADDR_RAM_UB
                   || ioAddr == scd_pkg::SCD_ADDR_RAM_LB || ioAddr == scd_pkg::SCD_ADDR_ROM_UB;
  wire logic [7:0] rdMux =
      ioAddr == scd_pkg::SCD_ADDR_SYSCFG ? sysCfg_q :
      ioAddr == scd_pkg::SCD_ADDR_RAM_UB ? ramUb_q  :
      ioAddr == scd_pkg::SCD_ADDR_RAM_LB ? ramLb_q  :
      ioAddr == scd_pkg::SCD_ADDR_ROM_UB ? romUb_q  : 8'h00;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ioRdData <= 8'h00;
      ioRdHit  <= 1'b0;
    end else begin
      ioRdData <= ioRead ? rdMux : 8'h00;
      ioRdHit  <= ioRead && hitAny;
    end
  end

  assign cfg.exportDir  = sysCfg_q[scd_pkg::SCD_BIT_EXPORT];
  assign cfg.romDisable = sysCfg_q[scd_pkg::SCD_BIT_ROM_DIS];
  assign cfg.pinSel     = {sysCfg_q[scd_pkg::SCD_BIT_PINSEL_H],
                           sysCfg_q[scd_pkg::SCD_BIT_PINSEL_L]};
  assign cfg.daisyOrder = sysCfg_q[scd_pkg::SCD_BIT_DAISY];
  assign cfg.ramUpper   = ramUb_q;
  assign cfg.ramLower   = ramLb_q;
  assign cfg.romUpper   = romUb_q;

  // Daisy input is a pin: two flops before use
  // Address comes from the CPU on this clock: no sync, else selects lag the cycle kind
  logic daisyMeta_q;
  logic daisySync_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      daisyMeta_q <= 1'h0;
      daisySync_q <= 1'h0;
    end else begin
      daisyMeta_q <= daisyChainIn;
      daisySync_q <= daisyMeta_q;
    end
  end

  scd_bus_direction uDir (
    .clk       (clk),
    .rstn      (rstn),
    .cfg       (cfg),
    .cycle     (cycle),
    .busMaster (busMaster),
    .daisyIn   (daisySync_q),
    .dataOe    (dataOe),
    .dataIn    (dataIn)
  );

  wire logic memCycle = cycle == scd_pkg::SCD_CYC_MEM_RD
                     || cycle == scd_pkg::SCD_CYC_MEM_WR;

  scd_chip_select uCs (
    .clk        (clk),
    .rstn       (rstn),
    .cfg        (cfg),
    .memCycle   (memCycle),
    .addrHigh   (memAddrHigh), // Bit 6 is CPU A18 before timer muxing
    .romSelectN (romSelectN),
    .ramSelectN (ramSelectN)
  );

  // Bit 1 is shared by pin select and channel select, as in the register layout
  wire logic chanMode1 = sysCfg_q[scd_pkg::SCD_BIT_CHANSEL];
  wire scd_pkg::scd_pins_t pinMode =
      cfg.pinSel == 2'b11 ? scd_pkg::SCD_PINS_HOST :
      cfg.pinSel == 2'b10 ? scd_pkg::SCD_PINS_CHAN_B : scd_pkg::SCD_PINS_SERIAL;
  wire logic [2:0] pinMux =
      pinMode == scd_pkg::SCD_PINS_HOST   ?
        {hostReceiveReadyN, hostTransmitReadyN, hostInterrupt} :
      pinMode == scd_pkg::SCD_PINS_CHAN_B ?
        {chanBRequestToSendN, chanBReadyReqN, chanBWaitReqN} :
        {dma1TransferEndN, clockedSerialTransmit, clockedSerialClock};

  // No priority here: either pending source asserts the shared request; the rank only goes out on hostPortFirst
  wire logic irqAny = serialIrq || hostPortIrq;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      muxPinOut          <= 3'h7;
      muxPinMode         <= scd_pkg::SCD_PINS_SERIAL;
      chanBOutEnable     <= 1'b1;
      parallelPortEnable <= 1'b1;
      hostPortEnable     <= 1'b0;
      sharedIrqZeroN     <= 1'b1;
      hostPortFirst      <= 1'b0;
    end else begin
      muxPinOut          <= pinMux;
      muxPinMode         <= pinMode;
      chanBOutEnable     <= !chanMode1;
      parallelPortEnable <= !chanMode1;
      hostPortEnable     <= chanMode1;
      sharedIrqZeroN     <= !irqAny;
      hostPortFirst      <= cfg.daisyOrder;
    end
  end
endmodule

/* File: tb/scd_mem_model.sv */
// Behavioural external ROM and RAM pair answering the two chip selects
module scd_mem_model (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       romSelectN,
  input  wire logic       ramSelectN,
  output logic      [1:0] chipHit
);
  timeunit 1ns;
  timeprecision 1ps;
  // Which device answered the cycle; this side carries no obligations
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) chipHit <= 2'h0;
    else chipHit <= {~romSelectN, ~ramSelectN};
  end
endmodule

/* File: tb/scd_top_props.sv */
// Concurrent checks on the configuration and chip-select top ports
module scd_top_props (
  input wire logic                clk,
  input wire logic                rstn,
  input wire logic [7:0]          ioAddr,
  input wire logic                ioWrite,
  input wire logic [7:0]          ioWrData,
  input wire scd_pkg::scd_cycle_t cycle,
  input wire logic                busMaster,
  input wire logic                dataOe,
  input wire logic                dataIn,
  input wire logic                romSelectN,
  input wire logic                ramSelectN,
  input wire scd_pkg::scd_pins_t  muxPinMode,
  input wire logic                hostPortEnable,
  input wire logic                serialIrq,
  input wire logic                hostPortIrq,
  input wire logic                sharedIrqZeroN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cfgQ;
  // Shadow of the configuration byte, rebuilt from writes seen at the ports
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) cfgQ <= scd_pkg::SCD_SYSCFG_RESET;
    else if (ioWrite && ioAddr == scd_pkg::SCD_ADDR_SYSCFG) cfgQ <= ioWrData;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_WR_DRIVE: assert property (
    busMaster && cycle == scd_pkg::SCD_CYC_MEM_WR |=> dataOe && !dataIn)
    else $error("Data bus not driven on master write");
  AST_IDLE_FLOAT: assert property (
    cycle inside {scd_pkg::SCD_CYC_IDLE, scd_pkg::SCD_CYC_REFRESH} |=> !dataOe && !dataIn)
    else $error("Data bus not floating in idle or refresh");
  AST_SLAVE_FLOAT: assert property (
    !busMaster && cycle == scd_pkg::SCD_CYC_IO_WR_OFF |=> !dataOe && !dataIn)
    else $error("Data bus driven while not owning the bus");
  AST_EXPORT_READ: assert property (
    busMaster && cycle == scd_pkg::SCD_CYC_IO_RD_ON |=> dataOe == $past(cfgQ[4]) && !dataIn)
    else $error("On-chip read direction ignores export bit");
  AST_ROM_FIRST: assert property (
    !romSelectN |-> ramSelectN)
    else $error("Both selects active together");
  AST_ROM_OFF: assert property (
    cfgQ[3] |=> romSelectN)
    else $error("ROM select active while disabled");
  AST_MEM_ONLY: assert property (
    !(cycle inside {scd_pkg::SCD_CYC_MEM_RD, scd_pkg::SCD_CYC_MEM_WR})
      |=> romSelectN && ramSelectN)
    else $error("Select active outside a memory cycle");
  AST_HOST_MODE: assert property (
    cfgQ[2:1] == 2'h3 |=> muxPinMode == scd_pkg::SCD_PINS_HOST && hostPortEnable)
    else $error("Host pin routing not selected");
  AST_IRQ_SHARE: assert property (
    serialIrq || hostPortIrq |=> !sharedIrqZeroN)
    else $error("Shared interrupt line not asserted");
endmodule

/* File: tb/sysconfig_chip_select_decode_bench.sv */
// Self-checking bench for the configuration and chip-select block
module sysconfig_chip_select_decode_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, ioWrite, ioRead, busMaster, daisyChainIn, serialIrq, hostPortIrq;
  logic ioRdHit, dataOe, dataIn, romSelectN, ramSelectN, chanBOutEnable, parallelPortEnable;
  logic hostPortEnable, sharedIrqZeroN, hostPortFirst, dma1TransferEndN, clockedSerialTransmit;
  logic clockedSerialClock, chanBRequestToSendN, chanBReadyReqN, chanBWaitReqN;
  logic hostReceiveReadyN, hostTransmitReadyN, hostInterrupt;
  logic [7:0] ioAddr, ioWrData, memAddrHigh, ioRdData;
  logic [2:0] muxPinOut;
  logic [1:0] chipHit;
  scd_pkg::scd_cycle_t cycle;
  scd_pkg::scd_pins_t  muxPinMode;
  int fail_count;
  int compares;
  scd_top uut (.*);
  scd_mem_model mem (.clk, .rstn, .romSelectN, .ramSelectN, .chipHit);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk);
    ioAddr = a;
    ioWrData = d;
    ioWrite = 1'b1;
    @(negedge clk);
    ioWrite = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e, input logic h);
    @(negedge clk);
    ioAddr = a;
    ioRead = 1'b1;
    @(negedge clk);
    ioRead = 1'b0;
    chk(ioRdData, e);
    chk({7'h0, ioRdHit}, {7'h0, h});
  endtask
  task automatic t_regs;
    rd(scd_pkg::SCD_ADDR_RAM_UB, 8'hff, 1'b1);
    rd(scd_pkg::SCD_ADDR_RAM_LB, 8'hff, 1'b1);
    rd(scd_pkg::SCD_ADDR_ROM_UB, 8'hff, 1'b1);
    rd(8'he5, 8'h00, 1'b0);
    wr(scd_pkg::SCD_ADDR_RAM_LB, 8'h5a);
    rd(scd_pkg::SCD_ADDR_RAM_LB, 8'h5a, 1'b1);
    $display("Test registers done");
  endtask
  function automatic logic [7:0] dirExp(input logic m, e, d, input scd_pkg::scd_cycle_t c);
    case (c)
      scd_pkg::SCD_CYC_IO_WR_ON, scd_pkg::SCD_CYC_IO_WR_OFF: return m ? 8'h02 : 8'h00;
      scd_pkg::SCD_CYC_MEM_WR: return m ? 8'h02 : 8'h00;
      scd_pkg::SCD_CYC_IO_RD_ON: return (!m || e) ? 8'h02 : 8'h00;
      scd_pkg::SCD_CYC_IO_RD_OFF: return m ? 8'h01 : 8'h00;
      scd_pkg::SCD_CYC_MEM_RD: return 8'h01;
      scd_pkg::SCD_CYC_INTACK: return !d ? 8'h01 : ((!m || e) ? 8'h02 : 8'h00);
      default: return 8'h00;
    endcase
  endfunction
  task automatic t_dir;
    for (int k = 0; k < 8; k++) begin
      wr(scd_pkg::SCD_ADDR_SYSCFG, {3'h0, k[0], 4'h0});
      busMaster = k[1];
      daisyChainIn = k[2];
      for (int c = 0; c < 9; c++) begin
        cycle = scd_pkg::scd_cycle_t'(c);
        // Daisy input passes a two-flop synchroniser first
        repeat (4) @(negedge clk);
        chk({6'h0, dataOe, dataIn}, dirExp(k[1], k[0], k[2], cycle));
      end
    end
    $display("Test bus direction done");
  endtask
  task automatic t_cfg;
    for (int k = 0; k < 16; k++) begin
      wr(scd_pkg::SCD_ADDR_SYSCFG, {5'h0, k[2:0]});
      // Each source group carries its own pattern so a wrong route shows
      {dma1TransferEndN, clockedSerialTransmit, clockedSerialClock} = {k[3], !k[3], k[3]};
      {chanBRequestToSendN, chanBReadyReqN, chanBWaitReqN} = {!k[3], k[3], k[3]};
      {hostReceiveReadyN, hostTransmitReadyN, hostInterrupt} = {k[3], k[3], !k[3]};
      serialIrq = k[0];
      hostPortIrq = k[1];
      repeat (4) @(negedge clk);
      chk(muxPinMode, k[2] ? (k[1] ? scd_pkg::SCD_PINS_HOST : scd_pkg::SCD_PINS_CHAN_B)
                           : scd_pkg::SCD_PINS_SERIAL);
      chk({5'h0, muxPinOut}, {5'h0, (k[2] && k[1]) ? {k[3], k[3], !k[3]}
                                  : k[2] ? {!k[3], k[3], k[3]} : {k[3], !k[3], k[3]}});
      chk({5'h0, hostPortEnable, parallelPortEnable, chanBOutEnable},
          {5'h0, k[1], !k[1], !k[1]});
      chk({7'h0, hostPortFirst}, {7'h0, k[0]});
      chk({7'h0, sharedIrqZeroN}, {7'h0, !(k[0] | k[1])});
    end
    $display("Test configuration fields done");
  endtask
  task automatic probe(input logic [7:0] rb, lb, ub, input logic dis);
    logic [7:0] adr [7] = '{8'h00, 8'h07, 8'h08, 8'h0f, 8'h10, 8'h4c, 8'h80};
    logic r;
    logic m;
    wr(scd_pkg::SCD_ADDR_ROM_UB, rb);
    wr(scd_pkg::SCD_ADDR_RAM_LB, lb);
    wr(scd_pkg::SCD_ADDR_RAM_UB, ub);
    wr(scd_pkg::SCD_ADDR_SYSCFG, {4'h0, dis, 3'h0});
    for (int i = 0; i < 21; i++) begin
      memAddrHigh = adr[i % 7];
      cycle = (i < 7) ? scd_pkg::SCD_CYC_MEM_RD
            : (i < 14) ? scd_pkg::SCD_CYC_MEM_WR : scd_pkg::SCD_CYC_IO_RD_OFF;
      repeat (5) @(negedge clk);
      r = i < 14 && !dis && memAddrHigh <= rb;
      m = i < 14 && !r && memAddrHigh <= ub && memAddrHigh >= lb;
      chk({6'h0, chipHit}, {6'h0, r, m});
    end
    $display("Test chip selects done");
  endtask
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    {ioWrite, ioRead, busMaster, daisyChainIn, serialIrq, hostPortIrq, hostInterrupt} = '0;
    {dma1TransferEndN, clockedSerialTransmit, clockedSerialClock, chanBRequestToSendN} = '0;
    {chanBReadyReqN, chanBWaitReqN, hostReceiveReadyN, hostTransmitReadyN} = '0;
    {ioAddr, ioWrData, memAddrHigh} = '0;
    cycle = scd_pkg::SCD_CYC_IDLE;
    fail_count = 0;
    compares = 0;
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    t_regs();
    t_dir();
    t_cfg();
    probe(8'h0f, 8'h10, 8'h7f, 1'b0);
    probe(8'h0f, 8'h08, 8'h7f, 1'b0);
    probe(8'h0f, 8'h08, 8'h7f, 1'b1);
    final_report();
  end
  initial begin
    #300000;
    fail_count++;
    final_report();
  end
endmodule
bind scd_top scd_top_props chk_i (.*);
